// [hdl/bst_map.vh]
// Constants for the boundary-scan test port.
// Contract
// [RQ1] Only four test pins: clock, mode select, data in, data out; no test reset.
// [RQ2] Internal reset forces the controller into Test-Logic-Reset.
// [RQ3] Test data out shares one pin with the half line-locked clock.
// [RQ4] Board boundary test only; no internal test, no self-test.
// [RQ5] Controller steps on test clock by mode select; states drive capture, shift, update.
// [RQ6] Instruction path in IR branch; instruction picks the data register in DR branch.
// [RQ7] Decoder supports bypass, sample/preload, extest, vendor test, identification, highz, clamp.
// [RQ8] Highz floats outputs, clamp drives from cells; both select bypass.
// [RQ9] Boundary chain links pad cells serially; samples inputs, drives outputs.
// [RQ10] Input cell: capture pin, shift from neighbour, nothing on update.
// [RQ11] Output cell: capture flop from system or neighbour, update flop loaded from it.
// [RQ12] Under extest pins follow update flops, otherwise system logic; code uses update flops under clamp too.
// [RQ13] Four output-type cells steer the enables of the tristate groups.
// [RQ14] Pixel clock pin uses one input cell plus one tristate-control cell.
// [RQ15] Bypass is a one-stage serial path.
// [RQ16] Identification register: 32 bits, maker code, part number, revision.
// [RQ17] Vendor test register: 8 bits, shift and update only, no capture.
// [RQ18] Instruction register three bits, no parity, captures 101.
// [RQ19] Codes 100 to 111 select bypass; identification selected after reset.
// [RQ20] In Test-Logic-Reset shared pin carries half clock, else test data out.
// [RQ21] Boundary chain holds exactly 38 cells in fixed pin order.
// [RQ22] Codes: extest 000, sample 001, id 010, vendor 011, highz 100, clamp 110.
// [RQ23] Inputs sampled on rising test clock; data out changes on falling edge.
`ifndef BST_MAP_VH
`define BST_MAP_VH

// ----------------------------------------
// Instruction register
// ----------------------------------------
`define BST_IR_W 3
`define BST_IR_EXTEST 3'h0
`define BST_IR_SAMPLE 3'h1
`define BST_IR_IDCODE 3'h2
`define BST_IR_VTEST 3'h3
`define BST_IR_HIGHZ 3'h4
`define BST_IR_CLAMP 3'h6
`define BST_IR_CAPTURE 3'h5

// ----------------------------------------
// Data registers
// ----------------------------------------
`define BST_ID_W 32
`define BST_VT_W 8
`define BST_VT_RESET 8'h00
`define BST_ID_VERSION 4'h1
`define BST_ID_PART 16'h0001
`define BST_ID_MAKER 11'h0aa

// ----------------------------------------
// Boundary chain layout, input cells first from the scan-out end
// ----------------------------------------
`define BST_N_IN 13
`define BST_N_OUT 21
`define BST_N_TRI 4
`define BST_N_CELLS 38
`define BST_TRI_PIXEL_CLOCK_PIN 3

// ----------------------------------------
// Synchroniser width: test clock, mode, data in, then the input pins
// ----------------------------------------
`define BST_SYNC_W 16

`endif

// [hdl/bst_sync.v]
// Two-flop synchroniser for pins from outside the clock domain.
module bst_sync #(
	parameter W = 1
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Asynchronous levels in, synchronised levels out
	input wire [W-1:0] d,
	output wire [W-1:0] q
);

	genvar i;

	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg meta_r;
			reg sync_r;
			// Only the second flop is visible outside.
			always @(posedge clk) begin
				if (rst) begin
					meta_r <= 1'b0;
					sync_r <= 1'b0;
				end else begin
					meta_r <= d[i];
					sync_r <= meta_r;
				end
			end
			assign q[i] = sync_r;
		end
	endgenerate

endmodule

// [hdl/bst_chain.v]
// Boundary chain: input, output and tristate-control cells in one shift path.
`include "bst_map.vh"

module bst_chain (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Controller actions, one-cycle pulses
	input wire cap_en,
	input wire shift_en,
	input wire upd_en,
	// Serial path
	input wire scan_in,
	output wire scan_out,
	// Values captured into the cells
	input wire [`BST_N_IN-1:0] pin_in,
	input wire [`BST_N_OUT-1:0] sys_out,
	input wire [`BST_N_TRI-1:0] sys_oe,
	// Update flops of output and tristate cells
	output wire [`BST_N_OUT-1:0] upd_out,
	output wire [`BST_N_TRI-1:0] upd_oe
);

	localparam NC = `BST_N_CELLS;
	localparam NI = `BST_N_IN;

	wire [NC-1:0] cap_src;
	wire [NC:0] chain;
	reg [NC-1:0] cap_r;
	wire [NC-1:NI] upd_w;

	assign cap_src = {sys_oe, sys_out, pin_in}; // RQ9
	assign chain = {scan_in, cap_r};
	assign scan_out = cap_r[0];

	genvar i;

	generate
		for (i = 0; i < NC; i = i + 1) begin : g_cell
			always @(posedge clk) begin
				if (rst) begin
					cap_r[i] <= 1'b0;
				end else if (cap_en) begin
					cap_r[i] <= cap_src[i]; // RQ10 RQ11
				end else if (shift_en) begin
					cap_r[i] <= chain[i+1]; // RQ9
				end
			end
			if (i >= NI) begin : g_upd
				reg upd_r;
				// Input cells have no update flop at all.
				always @(posedge clk) begin
					if (rst) begin
						upd_r <= 1'b0;
					end else if (upd_en) begin
						upd_r <= cap_r[i]; // RQ11 RQ13
					end
				end
				assign upd_w[i] = upd_r;
			end
		end
	endgenerate

	assign upd_out = upd_w[NI+`BST_N_OUT-1:NI];
	assign upd_oe = upd_w[NC-1:NI+`BST_N_OUT];

endmodule

// [hdl/bst_tap.v]
// Boundary-scan test access port: controller, instructions and data registers.
`include "bst_map.vh"

module bst_tap #(
	parameter [3:0] ID_VERSION = `BST_ID_VERSION,
	parameter [15:0] ID_PART = `BST_ID_PART,
	// Arbitrary neutral maker code.
	parameter [10:0] ID_MAKER = `BST_ID_MAKER
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Test port pins
	input wire tck_pin,
	input wire tms_pin,
	input wire tdi_pin,
	// Shared test data out and half line-locked clock pin
	input wire half_line_locked_clock,
	output wire shared_pin_out,
	output wire shared_pin_oe,
	// Boundary pins; pin_in[0] is the pixel clock pin input
	input wire [`BST_N_IN-1:0] pin_in,
	input wire [`BST_N_OUT-1:0] sys_out,
	input wire [`BST_N_TRI-1:0] sys_oe,
	output wire [`BST_N_OUT-1:0] pad_out,
	output wire [`BST_N_TRI-1:0] pad_oe,
	// Pixel clock pin output; its enable is pad_oe[3]
	input wire sys_pixel_clock,
	output wire pixel_clock_pin_out,
	// Vendor test register contents
	output wire [`BST_VT_W-1:0] test_reg_out
);

	// ----------------------------------------
	// Controller states
	// ----------------------------------------
	localparam [3:0] S_TLR = 4'h0;
	localparam [3:0] S_RTI = 4'h1;
	localparam [3:0] S_SEL_DR = 4'h2;
	localparam [3:0] S_CAP_DR = 4'h3;
	localparam [3:0] S_SH_DR = 4'h4;
	localparam [3:0] S_EX1_DR = 4'h5;
	localparam [3:0] S_PA_DR = 4'h6;
	localparam [3:0] S_EX2_DR = 4'h7;
	localparam [3:0] S_UP_DR = 4'h8;
	localparam [3:0] S_SEL_IR = 4'h9;
	localparam [3:0] S_CAP_IR = 4'ha;
	localparam [3:0] S_SH_IR = 4'hb;
	localparam [3:0] S_EX1_IR = 4'hc;
	localparam [3:0] S_PA_IR = 4'hd;
	localparam [3:0] S_EX2_IR = 4'he;
	localparam [3:0] S_UP_IR = 4'hf;

	localparam [`BST_ID_W-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

	// ----------------------------------------
	// Pin synchronisation and test clock edges
	// ----------------------------------------
	wire [`BST_SYNC_W-1:0] sync_q;
	wire tck_s;
	wire tms_s;
	wire tdi_s;
	wire [`BST_N_IN-1:0] pin_s;
	reg tck_d_r;
	wire tck_rise;
	wire tck_fall;

	// No test reset pin exists; only rst and the controller reset the port.
	bst_sync #(
		.W(`BST_SYNC_W)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.d({pin_in, tdi_pin, tms_pin, tck_pin}), // RQ1
		.q(sync_q)
	);

	assign tck_s = sync_q[0];
	assign tms_s = sync_q[1];
	assign tdi_s = sync_q[2];
	assign pin_s = sync_q[`BST_SYNC_W-1:3];

	always @(posedge clk) begin
		if (rst) begin
			tck_d_r <= 1'b0;
		end else begin
			tck_d_r <= tck_s;
		end
	end

	// The test clock must stay below a quarter of clk for edges to be seen.
	// Both edge flags are one-cycle pulses on clk.
	assign tck_rise = tck_s & ~tck_d_r; // RQ23
	assign tck_fall = ~tck_s & tck_d_r; // RQ23

	// ----------------------------------------
	// Controller
	// ----------------------------------------
	reg [3:0] state_r;
	reg [3:0] state_nxt;

	always @* begin
		case (state_r)
			S_TLR: state_nxt = tms_s ? S_TLR : S_RTI;
			S_RTI: state_nxt = tms_s ? S_SEL_DR : S_RTI;
			S_SEL_DR: state_nxt = tms_s ? S_SEL_IR : S_CAP_DR;
			S_CAP_DR: state_nxt = tms_s ? S_EX1_DR : S_SH_DR;
			S_SH_DR: state_nxt = tms_s ? S_EX1_DR : S_SH_DR;
			S_EX1_DR: state_nxt = tms_s ? S_UP_DR : S_PA_DR;
			S_PA_DR: state_nxt = tms_s ? S_EX2_DR : S_PA_DR;
			S_EX2_DR: state_nxt = tms_s ? S_UP_DR : S_SH_DR;
			S_UP_DR: state_nxt = tms_s ? S_SEL_DR : S_RTI;
			S_SEL_IR: state_nxt = tms_s ? S_TLR : S_CAP_IR;
			S_CAP_IR: state_nxt = tms_s ? S_EX1_IR : S_SH_IR;
			S_SH_IR: state_nxt = tms_s ? S_EX1_IR : S_SH_IR;
			S_EX1_IR: state_nxt = tms_s ? S_UP_IR : S_PA_IR;
			S_PA_IR: state_nxt = tms_s ? S_EX2_IR : S_PA_IR;
			S_EX2_IR: state_nxt = tms_s ? S_UP_IR : S_SH_IR;
			S_UP_IR: state_nxt = tms_s ? S_SEL_DR : S_RTI;
			default: state_nxt = S_TLR;
		endcase
	end

	always @(posedge clk) begin
		if (rst) begin
			state_r <= S_TLR; // RQ2
		end else if (tck_rise) begin
			state_r <= state_nxt; // RQ5
		end
	end

	// Actions fire on the rising edge that leaves the acting state.
	wire act_cap_dr;
	wire act_sh_dr;
	wire act_up_dr;
	wire in_tlr;

	assign act_cap_dr = tck_rise & (state_r == S_CAP_DR); // RQ5
	assign act_sh_dr = tck_rise & (state_r == S_SH_DR); // RQ5
	assign act_up_dr = tck_rise & (state_r == S_UP_DR); // RQ5
	assign in_tlr = (state_r == S_TLR);

	// ----------------------------------------
	// Shift-state flags
	// ----------------------------------------
	// Test data out is driven only while a shift is under way, so a chained
	// tester sees the pull-up level between frames.
	wire in_sh_ir;
	wire in_sh_dr;

	assign in_sh_ir = (state_r == S_SH_IR);
	assign in_sh_dr = (state_r == S_SH_DR);

	// ----------------------------------------
	// Instruction register
	// ----------------------------------------
	reg [`BST_IR_W-1:0] ir_r;
	reg [`BST_IR_W-1:0] ir_sh_r;

	// The active code changes only in Update-IR or Test-Logic-Reset, so pads never see a half-shifted code.
	always @(posedge clk) begin
		if (rst) begin
			ir_r <= `BST_IR_IDCODE; // RQ19
			ir_sh_r <= `BST_IR_CAPTURE;
		end else if (tck_rise) begin
			if (in_tlr) begin
				ir_r <= `BST_IR_IDCODE; // RQ19
			end
			case (state_r)
				S_CAP_IR: ir_sh_r <= `BST_IR_CAPTURE; // RQ18
				S_SH_IR: ir_sh_r <= {tdi_s, ir_sh_r[`BST_IR_W-1:1]}; // RQ6
				S_UP_IR: ir_r <= ir_sh_r; // RQ6
				default: ir_sh_r <= ir_sh_r;
			endcase
		end
	end

	// ----------------------------------------
	// Instruction decode
	// ----------------------------------------
	// No internal-test or self-test code exists; every other code is bypass.
	// Codes 101 and 111 therefore fall through to bypass as well.
	wire sel_bsr;
	wire sel_id;
	wire sel_vt;
	wire sel_byp;
	wire drive_cells;
	wire float_all;

	assign sel_bsr = (ir_r == `BST_IR_EXTEST) | (ir_r == `BST_IR_SAMPLE); // RQ22 RQ7 RQ4
	assign sel_id = (ir_r == `BST_IR_IDCODE); // RQ22 RQ7
	assign sel_vt = (ir_r == `BST_IR_VTEST); // RQ22 RQ7
	assign sel_byp = ~(sel_bsr | sel_id | sel_vt); // RQ19 RQ8
	assign drive_cells = (ir_r == `BST_IR_EXTEST) | (ir_r == `BST_IR_CLAMP); // RQ12 RQ8
	assign float_all = (ir_r == `BST_IR_HIGHZ); // RQ8

	// ----------------------------------------
	// Bypass and identification registers
	// ----------------------------------------
	reg byp_r;
	reg [`BST_ID_W-1:0] id_sh_r;

	always @(posedge clk) begin
		if (rst) begin
			byp_r <= 1'b0;
		end else if (act_cap_dr & sel_byp) begin
			byp_r <= 1'b0;
		end else if (act_sh_dr & sel_byp) begin
			byp_r <= tdi_s; // RQ15
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			id_sh_r <= ID_VALUE;
		end else if (act_cap_dr & sel_id) begin
			id_sh_r <= ID_VALUE; // RQ16
		end else if (act_sh_dr & sel_id) begin
			id_sh_r <= {tdi_s, id_sh_r[`BST_ID_W-1:1]}; // RQ16
		end
	end

	// ----------------------------------------
	// Vendor test register
	// ----------------------------------------
	// Without a capture step the shift stage keeps the last word for checking.
	reg [`BST_VT_W-1:0] vt_sh_r;
	reg [`BST_VT_W-1:0] vt_upd_r;

	always @(posedge clk) begin
		if (rst) begin
			vt_sh_r <= `BST_VT_RESET;
			vt_upd_r <= `BST_VT_RESET;
		end else if (act_sh_dr & sel_vt) begin
			vt_sh_r <= {tdi_s, vt_sh_r[`BST_VT_W-1:1]}; // RQ17
		end else if (act_up_dr & sel_vt) begin
			vt_upd_r <= vt_sh_r; // RQ17
		end
	end

	assign test_reg_out = vt_upd_r;

	// ----------------------------------------
	// Boundary chain
	// ----------------------------------------
	wire bsr_so;
	wire [`BST_N_OUT-1:0] upd_out;
	wire [`BST_N_TRI-1:0] upd_oe;

	// Pixel clock pin: input cell pin_in[0] plus tristate cell 3.
	bst_chain u_chain (
		.clk(clk),
		.rst(rst),
		.cap_en(act_cap_dr & sel_bsr), // RQ10 RQ11
		.shift_en(act_sh_dr & sel_bsr), // RQ9 RQ21
		.upd_en(act_up_dr & sel_bsr), // RQ11
		.scan_in(tdi_s),
		.scan_out(bsr_so),
		.pin_in(pin_s), // RQ14
		.sys_out(sys_out),
		.sys_oe(sys_oe),
		.upd_out(upd_out),
		.upd_oe(upd_oe)
	);

	// ----------------------------------------
	// Pad drive
	// ----------------------------------------
	reg [`BST_N_OUT-1:0] pad_out_r;
	reg [`BST_N_TRI-1:0] pad_oe_r;
	reg pix_out_r;

	// Highz wins over clamp and extest, so the pads float even with driving cells.
	always @(posedge clk) begin
		if (rst) begin
			pad_out_r <= {`BST_N_OUT{1'b0}};
			pad_oe_r <= {`BST_N_TRI{1'b0}};
			pix_out_r <= 1'b0;
		end else begin
			pix_out_r <= sys_pixel_clock;
			pad_out_r <= drive_cells ? upd_out : sys_out; // RQ12
			if (float_all) begin
				pad_oe_r <= {`BST_N_TRI{1'b0}}; // RQ8
			end else begin
				pad_oe_r <= drive_cells ? upd_oe : sys_oe; // RQ13
			end
		end
	end

	assign pad_out = pad_out_r;
	assign pad_oe = pad_oe_r;
	assign pixel_clock_pin_out = pix_out_r;

	// ----------------------------------------
	// Test data out and the shared pin
	// ----------------------------------------
	reg tdo_nxt;
	reg tdo_r;
	reg tdo_oe_r;
	reg shared_out_r;
	reg shared_oe_r;

	always @* begin
		if (in_sh_ir) begin
			tdo_nxt = ir_sh_r[0]; // RQ6
		end else if (sel_bsr) begin
			tdo_nxt = bsr_so; // RQ6
		end else if (sel_id) begin
			tdo_nxt = id_sh_r[0];
		end else if (sel_vt) begin
			tdo_nxt = vt_sh_r[0];
		end else begin
			tdo_nxt = byp_r;
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			tdo_r <= 1'b0;
			tdo_oe_r <= 1'b0;
		end else if (tck_fall) begin
			tdo_r <= tdo_nxt; // RQ23
			tdo_oe_r <= in_sh_ir | in_sh_dr; // RQ23
		end
	end

	// The pin is never released in Test-Logic-Reset, so boards downstream
	// of this device cannot be scanned through it.
	always @(posedge clk) begin
		if (rst) begin
			shared_out_r <= 1'b0;
			shared_oe_r <= 1'b1;
		end else if (in_tlr) begin
			shared_out_r <= half_line_locked_clock; // RQ20 RQ3
			shared_oe_r <= 1'b1; // RQ20
		end else begin
			shared_out_r <= tdo_r; // RQ20 RQ3
			shared_oe_r <= tdo_oe_r; // RQ20
		end
	end

	assign shared_pin_out = shared_out_r;
	assign shared_pin_oe = shared_oe_r;

endmodule

// [sim/bst_tap_asserts.sv]
// Checker on the ports of the boundary-scan test port.
`include "bst_map.vh"

module bst_tap_asserts (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Test pins
	input wire tck_pin,
	input wire tms_pin,
	input wire half_line_locked_clock,
	input wire shared_pin_out,
	input wire shared_pin_oe,
	// Boundary pins
	input wire [`BST_N_OUT-1:0] sys_out,
	input wire [`BST_N_TRI-1:0] sys_oe,
	input wire [`BST_N_OUT-1:0] pad_out,
	input wire [`BST_N_TRI-1:0] pad_oe,
	input wire [`BST_VT_W-1:0] test_reg_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// Test clock edge ages
	// ----
	// The pins are seen raw, ahead of the port's synchroniser, so the windows keep some slack.
	// The reset-state flag only covers the stay after rst, not a return through the mode pin.
	logic tck_d_r;
	logic tlr_r;
	logic [15:0] tlr_q_r;
	logic [7:0] rise_age_r;
	logic [7:0] fall_age_r;
	wire tck_rise = tck_pin && !tck_d_r;
	wire tck_fall = !tck_pin && tck_d_r;

	always_ff @(posedge clk) begin
		tck_d_r <= tck_pin;
		if (rst) begin
			tlr_r <= 1'h1;
			tlr_q_r <= 16'hffff;
			rise_age_r <= 8'hff;
			fall_age_r <= 8'hff;
		end else begin
			if (tck_rise && !tms_pin)
				tlr_r <= 1'h0;
			tlr_q_r <= {tlr_q_r[14:0], tlr_r};
			rise_age_r <= tck_rise ? 8'h00 : rise_age_r + {7'h00, rise_age_r != 8'hff};
			fall_age_r <= tck_fall ? 8'h00 : fall_age_r + {7'h00, fall_age_r != 8'hff};
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_settled;
		!tlr_r && tlr_q_r == 16'h0000;
	endsequence
	sequence s_after_fall;
		fall_age_r >= 8'h02 && fall_age_r <= 8'h07;
	endsequence

	property p_reset_state;
		disable iff (1'h0) rst |=> shared_pin_oe && pad_oe == 4'h0 && test_reg_out == 8'h00;
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("reset state wrong");
	property p_tlr_clock;
		tlr_r && $past(tlr_r) && !$past(rst, 2)
			|-> shared_pin_oe && shared_pin_out == $past(half_line_locked_clock);
	endproperty
	a_tlr_clock: assert property (p_tlr_clock)
		else $error("shared pin not carrying half clock");
	property p_tlr_pads;
		tlr_r && !$past(rst) |-> pad_out == $past(sys_out) && pad_oe == $past(sys_oe);
	endproperty
	a_tlr_pads: assert property (p_tlr_pads)
		else $error("pads not on system path");
	property p_vt_cause;
		$changed(test_reg_out) |-> rise_age_r <= 8'h08;
	endproperty
	a_vt_cause: assert property (p_vt_cause)
		else $error("test register changed without test clock");
	property p_tdo_fall;
		s_settled ##0 $changed(shared_pin_out) |-> s_after_fall;
	endproperty
	a_tdo_fall: assert property (p_tdo_fall)
		else $error("test data out changed away from falling edge");
	property p_tdo_oe;
		s_settled ##0 $changed(shared_pin_oe) |-> rise_age_r <= 8'h08 || fall_age_r <= 8'h08;
	endproperty
	a_tdo_oe: assert property (p_tdo_oe)
		else $error("shared pin enable changed with test clock idle");
	property p_oe_cause;
		!$past(rst, 2) && $changed(pad_oe)
			|-> rise_age_r <= 8'h08 || $past(sys_oe) != $past(sys_oe, 2);
	endproperty
	a_oe_cause: assert property (p_oe_cause)
		else $error("pad enable changed without cause");
	property p_out_cause;
		!$past(rst, 2) && $changed(pad_out)
			|-> rise_age_r <= 8'h08 || $past(sys_out) != $past(sys_out, 2);
	endproperty
	a_out_cause: assert property (p_out_cause)
		else $error("pad output changed without cause");
endmodule

bind bst_tap bst_tap_asserts u_chk (
	.clk(clk), .rst(rst), .tck_pin(tck_pin), .tms_pin(tms_pin),
	.half_line_locked_clock(half_line_locked_clock), .shared_pin_out(shared_pin_out),
	.shared_pin_oe(shared_pin_oe), .sys_out(sys_out), .sys_oe(sys_oe),
	.pad_out(pad_out), .pad_oe(pad_oe), .test_reg_out(test_reg_out)
);

// [sim/bst_tester.sv]
// Behavioural board tester driving the test pins.
module bst_tester (
	// Test pins
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo,
	// Bits read back by the last scan
	output logic res_v,
	output logic [37:0] res_d
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h0;
		res_v = 1'h0;
		res_d = '0;
	end

	// ----
	// One test clock period of 160 ns
	// ----
	// The clock stands low between frames. The bit is read late in the high phase, where
	// the port's output has settled well after the previous fall.
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#80;
		tck = 1'h1;
		#79;
		q = tdo;
		#1;
		tck = 1'h0;
	endtask

	task automatic enter_idle;
		logic q;
		#7;
		step(1'h0, 1'h0, q);
	endtask

	task automatic scan(input logic ir, input logic [37:0] din, input int n);
		logic q;
		#7;
		step(1'h1, 1'h0, q);
		if (ir)
			step(1'h1, 1'h0, q);
		step(1'h0, 1'h0, q);
		step(1'h0, 1'h0, q);
		res_d = '0;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			res_d[i] = q;
		end
		step(1'h1, 1'h0, q);
		step(1'h0, 1'h0, q);
		tdi = ~tdi;
		res_v = 1'h1;
		#20;
		res_v = 1'h0;
	endtask
endmodule

// [sim/bst_tap_tb.sv]
// Self-checking bench for the boundary-scan test port.
`include "bst_map.vh"

module bst_tap_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Arbitrary identification values, only chosen to differ from the defaults.
	localparam logic [3:0] VER = 4'h2;
	localparam logic [15:0] PART = 16'h5a3c;
	localparam logic [10:0] MAKER = 11'h123;

	logic clk;
	logic rst;
	logic half_line_locked_clock;
	logic sys_pixel_clock;
	logic [`BST_N_IN-1:0] pin_in;
	logic [`BST_N_OUT-1:0] sys_out;
	logic [`BST_N_TRI-1:0] sys_oe;
	wire shared_pin_out;
	wire shared_pin_oe;
	wire [`BST_N_OUT-1:0] pad_out;
	wire [`BST_N_TRI-1:0] pad_oe;
	wire pixel_clock_pin_out;
	wire [`BST_VT_W-1:0] test_reg_out;
	wire tck;
	wire tms;
	wire tdi;
	wire res_v;
	wire [37:0] res_d;
	// The shared pin is pulled up while the port leaves it floating.
	wire tdo_pin = shared_pin_oe ? shared_pin_out : 1'h1;
	int seed;
	int miscompares = 0;
	int checks_done = 0;
	logic [37:0] expq[$];
	logic [37:0] pre;
	logic [31:0] r;
	logic [2:0] codes[4] = '{3'h4, 3'h5, 3'h6, 3'h7};

	bst_tap #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER)) DUT (
		.clk(clk), .rst(rst), .tck_pin(tck), .tms_pin(tms), .tdi_pin(tdi),
		.half_line_locked_clock(half_line_locked_clock), .shared_pin_out(shared_pin_out),
		.shared_pin_oe(shared_pin_oe), .pin_in(pin_in), .sys_out(sys_out), .sys_oe(sys_oe),
		.pad_out(pad_out), .pad_oe(pad_oe), .sys_pixel_clock(sys_pixel_clock),
		.pixel_clock_pin_out(pixel_clock_pin_out), .test_reg_out(test_reg_out)
	);
	bst_tester u_tst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_pin), .res_v(res_v), .res_d(res_d));

	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		half_line_locked_clock <= ~half_line_locked_clock;
		sys_pixel_clock <= half_line_locked_clock;
	end

	// ----
	// Checking
	// ----
	task automatic chk(input string nm, input logic [37:0] seen, input logic [37:0] want);
		checks_done++;
		if (seen !== want) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, want, seen);
		end
	endtask

	always @(posedge res_v) begin
		if (expq.size() == 0) begin
			miscompares++;
			$display("[ERR] scan expected none seen %h", res_d);
		end else
			chk("scan", res_d, expq.pop_front());
	end

	task automatic test_done;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#1000us;
		miscompares++;
		test_done;
	end

	// ----
	// Stimulus
	// ----
	task automatic sc(input logic ir, input logic [37:0] d, input int n, input logic [37:0] e);
		expq.push_back(e);
		u_tst.scan(ir, d, n);
		@(posedge clk);
	endtask

	task automatic ld(input logic [2:0] c);
		sc(1'h1, {35'h0, c}, 3, 38'h5);
	endtask

	task automatic pads(input logic [20:0] o, input logic [3:0] e, input logic use_o);
		logic p;
		repeat (5) @(posedge clk);
		#1;
		if (use_o)
			chk("pad_out", 38'(pad_out), 38'(o));
		chk("pad_oe", 38'(pad_oe), 38'(e));
		p = sys_pixel_clock;
		@(posedge clk);
		#1;
		chk("pixel_clock_pin", 38'(pixel_clock_pin_out), 38'(p));
	endtask

	task automatic rnd;
		@(posedge clk);
		r = $random(seed);
		pin_in <= r[12:0];
		sys_oe <= r[16:13];
		sys_out <= 21'($random(seed));
		repeat (5) @(posedge clk);
	endtask

	initial begin
		seed = 19789;
		rst = 1'h1;
		half_line_locked_clock = 1'h0;
		sys_pixel_clock = 1'h0;
		pin_in = '0;
		sys_out = '0;
		sys_oe = '0;
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		rnd;
		chk("tdo_oe", 38'(shared_pin_oe), 38'h1);
		chk("vtest", 38'(test_reg_out), 38'(`BST_VT_RESET));
		u_tst.enter_idle;
		sc(1'h0, 38'h0, 32, {6'h0, VER, PART, MAKER, 1'h1});
		chk("tdo_oe", 38'(shared_pin_oe), 38'h0);
		ld(`BST_IR_SAMPLE);
		pre = 38'({$random(seed), $random(seed)});
		sc(1'h0, pre, 38, {sys_oe, sys_out, pin_in});
		ld(`BST_IR_EXTEST);
		pads(pre[33:13], pre[37:34], 1'h1);
		foreach (codes[i]) begin
			ld(codes[i]);
			r = $random(seed);
			sc(1'h0, 38'(r[3:0]), 4, {34'h0, r[2:0], 1'h0});
			if (codes[i] == `BST_IR_HIGHZ)
				pads(pre[33:13], 4'h0, 1'h0);
			if (codes[i] == `BST_IR_CLAMP)
				pads(pre[33:13], pre[37:34], 1'h1);
		end
		ld(`BST_IR_SAMPLE);
		rnd;
		pads(sys_out, sys_oe, 1'h1);
		ld(`BST_IR_IDCODE);
		sc(1'h0, 38'h0, 32, {6'h0, VER, PART, MAKER, 1'h1});
		ld(`BST_IR_VTEST);
		r = $random(seed);
		sc(1'h0, 38'(r[7:0]), 8, 38'(`BST_VT_RESET));
		repeat (4) @(posedge clk);
		chk("vtest", 38'(test_reg_out), 38'(r[7:0]));
		sc(1'h0, 38'(r[15:8]), 8, 38'(r[7:0]));
		repeat (4) @(posedge clk);
		chk("vtest", 38'(test_reg_out), 38'(r[15:8]));
		chk("pending", 38'(expq.size()), 38'h0);
		test_done;
	end
endmodule
